/* File: hw/fmm_move_multiple.v */
// Move-multiple decoder and data register file behind an Avalon-MM slave
// Operation
// - Direction bit: 0 loads, 1 stores
// - Two-bit list mode: static/dynamic, pre/post
// - Static list is a register select mask
// - Mask bit order reverses between address modes
// - Dynamic list holds data register number
// - Dynamic mask is low byte of register
// - Load accepts only listed memory modes
// - Store accepts only listed alterable modes
// - Coprocessor identity field selects the executor
// - At least six bus cycles per register
// - Address steps by twelve per register in predecrement and postincrement modes only
// - No conversion; status register left untouched
`timescale 1ns/10ps
`include "fmm_defines.vh"
module fmm_move_multiple (
  input  wire        mclk_i,
  input  wire        sys_rst_i,
  input  wire [7:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  output wire        busy_o,
  output wire        proto_err_o
);
  // Sequencer states
  localparam ST_IDLE = 2'h0;
  localparam ST_NEXT = 2'h1;
  localparam ST_MOVE = 2'h2;

  // Data registers carry no reset: a store before any load hands out unknowns
  reg [79:0] fp_data_reg [0:7];
  reg [79:0] stage_reg;
  reg [15:0] opword_reg;
  reg [15:0] extword_reg;
  reg [31:0] dynsrc_reg;
  reg [31:0] addr_reg;
  reg [31:0] float_status_reg;
  reg [2:0]  own_id_reg;
  reg [1:0]  state_reg;
  reg [7:0]  pend_reg;
  reg [2:0]  cur_reg;
  reg [2:0]  wcnt_reg;
  reg        busy_reg;
  reg        done_reg;
  reg        perr_reg;
  reg        idmiss_reg;
  reg        wait_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rd_next;
  reg [7:0]  mask;
  reg [7:0]  sel_vec;
  integer    k;

  // Bus decode; the two low address bits are ignored
  wire [7:0] waddr = {avs_address_i[7:2], 2'h0};
  wire       req = avs_read_i | avs_write_i;
  wire       acc = req & ~wait_reg;
  wire       wr_acc = avs_write_i & acc;
  wire       dir_store = extword_reg[`FMM_EX_DIR];
  wire       list_dyn = extword_reg[`FMM_MODE_DYN + `FMM_EX_MODE_LO];
  wire       list_post = extword_reg[`FMM_MODE_POST + `FMM_EX_MODE_LO];
  wire       ea_predec = fmm_ea_is(opword_reg, `FMM_EA_PREDEC);
  wire       ea_postinc = fmm_ea_is(opword_reg, `FMM_EA_POSTINC);
  wire       legal;
  wire       sel_found;
  wire [2:0] sel_idx;
  wire       data_acc = acc && (waddr == `FMM_A_DATA) && (state_reg == ST_MOVE) &&
                        (avs_write_i ^ dir_store);
  wire       go = wr_acc && (waddr == `FMM_A_CTRL) && avs_writedata_i[`FMM_CTRL_GO] &&
                  !busy_reg;

  // Byte-lane merge for software-written registers
  function [31:0] fmm_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer b;
    begin
      fmm_merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b])
          fmm_merge[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction

  // Word n of a register image: exponent, pad, then mantissa high to low
  function [15:0] fmm_img_word;
    input [79:0] val;
    input [2:0]  n;
    begin
      case (n)
        3'h0: fmm_img_word = val[79:64];
        3'h2: fmm_img_word = val[63:48];
        3'h3: fmm_img_word = val[47:32];
        3'h4: fmm_img_word = val[31:16];
        3'h5: fmm_img_word = val[15:0];
        default: fmm_img_word = 16'h0000;
      endcase
    end
  endfunction

  // Tests the address mode field of an operation word against one mode code
  function fmm_ea_is;
    input [15:0] op;
    input [2:0]  mode;
    begin
      fmm_ea_is = (op[`FMM_OP_EAM] == mode);
    end
  endfunction

  // Byte-merged command words; the upper half is dropped on purpose
  wire [31:0] op_merged = fmm_merge({16'h0000, opword_reg}, avs_writedata_i,
                                    avs_byteenable_i);
  wire [31:0] ext_merged = fmm_merge({16'h0000, extword_reg}, avs_writedata_i,
                                     avs_byteenable_i);
  // Command addressed to this coprocessor
  wire        id_hit = (opword_reg[`FMM_OP_ID] == own_id_reg);

  // Legality is judged on the frozen command words, never on live bus data
  fmm_ea_check u_check (
    .op_i    (opword_reg),
    .ext_i   (extword_reg),
    .legal_o (legal)
  );

  // Predecrement walks from the top register down
  fmm_next_sel u_sel (
    .pend_i  (pend_reg),
    .down_i  (~list_post),
    .found_o (sel_found),
    .idx_o   (sel_idx)
  );

  // Source mask: static list field or low byte of the named data register
  // Source words cannot change while busy, so the mask holds for the whole move
  always @* begin
    mask = list_dyn ? dynsrc_reg[7:0] : extword_reg[`FMM_EX_LIST];
    for (k = 0; k < 8; k = k + 1) begin
      // Predecrement: bit k selects register k; otherwise bit 7-k
      sel_vec[k] = list_post ? mask[7 - k] : mask[k];
    end
  end

  // Read data multiplexer; unmapped offsets read as zero
  // Status fields are placed one by one so unused bits stay zero
  always @* begin
    rd_next = `FMM_LONG_RST;
    case (waddr)
      `FMM_A_OPWORD: rd_next = {16'h0000, opword_reg};
      `FMM_A_EXTWORD: rd_next = {16'h0000, extword_reg};
      `FMM_A_DYNSRC: rd_next = dynsrc_reg;
      `FMM_A_ADDR: rd_next = addr_reg;
      `FMM_A_FSTAT: rd_next = float_status_reg;
      `FMM_A_IDCFG: rd_next = {29'h0, own_id_reg};
      `FMM_A_STATUS: begin
        rd_next[`FMM_ST_BUSY] = busy_reg;
        rd_next[`FMM_ST_DONE] = done_reg;
        rd_next[`FMM_ST_PERR] = perr_reg;
        rd_next[`FMM_ST_IDMISS] = idmiss_reg;
        rd_next[`FMM_ST_DIR] = dir_store;
        rd_next[`FMM_ST_DYN] = list_dyn;
        rd_next[`FMM_ST_CUR] = cur_reg;
        rd_next[`FMM_ST_DYNREG] = extword_reg[`FMM_DYN_REG];
        rd_next[`FMM_ST_WCNT] = wcnt_reg;
        rd_next[`FMM_ST_PEND] = pend_reg;
      end
      `FMM_A_DATA: begin
        // Store direction hands out the image one word per bus cycle
        if (state_reg == ST_MOVE && dir_store)
          rd_next = {16'h0000, fmm_img_word(fp_data_reg[cur_reg], wcnt_reg)};
      end
      default: rd_next = `FMM_LONG_RST;
    endcase
  end

  // Bus handshake: waitrequest drops for one cycle one edge after a request
  // Registered read data costs one wait state per access but keeps the
  // read path out of the output timing
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= `FMM_LONG_RST;
    end else if (req && wait_reg) begin
      wait_reg <= 1'b0;
      rdata_reg <= rd_next;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // Software-written configuration; command words are frozen while busy
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      opword_reg <= `FMM_WORD_RST;
      extword_reg <= `FMM_WORD_RST;
      dynsrc_reg <= `FMM_LONG_RST;
      float_status_reg <= `FMM_LONG_RST;
      own_id_reg <= `FMM_ID_RST;
    end else if (wr_acc && !busy_reg) begin
      case (waddr)
        `FMM_A_OPWORD: opword_reg <= op_merged[15:0];
        `FMM_A_EXTWORD: extword_reg <= ext_merged[15:0];
        `FMM_A_DYNSRC: dynsrc_reg <= fmm_merge(dynsrc_reg, avs_writedata_i,
                                               avs_byteenable_i);
        // Only software changes the status register; moves never do
        `FMM_A_FSTAT: float_status_reg <= fmm_merge(float_status_reg, avs_writedata_i,
                                                    avs_byteenable_i);
        `FMM_A_IDCFG: own_id_reg <= avs_writedata_i[2:0];
        default: own_id_reg <= own_id_reg;
      endcase
    end
  end

  // Transfer sequencer
  // A register is only retired after its sixth word, so a master that stops
  // early leaves the move busy until the remaining words arrive
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
      pend_reg <= 8'h00;
      cur_reg <= 3'h0;
      wcnt_reg <= 3'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      perr_reg <= 1'b0;
      idmiss_reg <= 1'b0;
      addr_reg <= `FMM_LONG_RST;
      stage_reg <= 80'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (wr_acc && waddr == `FMM_A_ADDR)
            addr_reg <= fmm_merge(addr_reg, avs_writedata_i, avs_byteenable_i);
          if (go) begin
            done_reg <= 1'b0;
            perr_reg <= 1'b0;
            idmiss_reg <= 1'b0;
            if (!id_hit) begin
              idmiss_reg <= 1'b1; // Not addressed to this coprocessor
            end else if (!legal) begin
              perr_reg <= 1'b1; // Nothing is moved
            end else begin
              busy_reg <= 1'b1;
              pend_reg <= sel_vec;
              state_reg <= ST_NEXT;
            end
          end
        end
        ST_NEXT: begin
          if (sel_found) begin
            cur_reg <= sel_idx;
            wcnt_reg <= 3'h0;
            if (ea_predec)
              addr_reg <= addr_reg - `FMM_IMG_BYTES; // Before each store
            state_reg <= ST_MOVE;
          end else begin
            // Empty or exhausted list ends the instruction
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_MOVE: begin
          if (data_acc) begin
            // Load assembles the image; pad word is dropped, no rounding
            case (wcnt_reg)
              3'h0: stage_reg[79:64] <= avs_writedata_i[15:0];
              3'h2: stage_reg[63:48] <= avs_writedata_i[15:0];
              3'h3: stage_reg[47:32] <= avs_writedata_i[15:0];
              3'h4: stage_reg[31:16] <= avs_writedata_i[15:0];
              default: stage_reg[15:0] <= avs_writedata_i[15:0];
            endcase
            if (wcnt_reg == `FMM_LAST_WORD) begin
              // Sixth bus cycle completes this register
              pend_reg[cur_reg] <= 1'b0;
              if (ea_postinc)
                addr_reg <= addr_reg + `FMM_IMG_BYTES; // After each load
              state_reg <= ST_NEXT;
            end else begin
              wcnt_reg <= wcnt_reg + 3'h1;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Register file load: last word joins the staged image
  // Kept apart from the sequencer because the data registers have no reset
  always @(posedge mclk_i) begin
    if (state_reg == ST_MOVE && data_acc && !dir_store && wcnt_reg == `FMM_LAST_WORD)
      fp_data_reg[cur_reg] <= {stage_reg[79:16], avs_writedata_i[15:0]};
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign busy_o = busy_reg;
  assign proto_err_o = perr_reg;
endmodule // fmm_move_multiple

/* File: inc/fmm_defines.vh */
// Constants for the multi-register floating-point move decoder
`ifndef FMM_DEFINES_VH
`define FMM_DEFINES_VH
// Register byte offsets
`define FMM_A_OPWORD 8'h00
`define FMM_A_EXTWORD 8'h04
`define FMM_A_DYNSRC 8'h08
`define FMM_A_ADDR 8'h0c
`define FMM_A_CTRL 8'h10
`define FMM_A_STATUS 8'h14
`define FMM_A_DATA 8'h18
`define FMM_A_FSTAT 8'h1c
`define FMM_A_IDCFG 8'h20
// Operation word fields
`define FMM_OP_SIG 15:12
`define FMM_OP_SIG_VAL 4'hf
`define FMM_OP_ID 11:9
`define FMM_OP_ZERO 8:6
`define FMM_OP_EAM 5:3
`define FMM_OP_EAR 2:0
// Extension word fields
`define FMM_EX_SIG 15:14
`define FMM_EX_SIG_VAL 2'h3
`define FMM_EX_DIR 13
`define FMM_EX_MODE 12:11
`define FMM_EX_MODE_LO 11
`define FMM_EX_ZERO 10:8
`define FMM_EX_LIST 7:0
`define FMM_DYN_REG 6:4
`define FMM_DYN_ZMASK 8'h8f
`define FMM_MODE_DYN 0
`define FMM_MODE_POST 1
// Effective address modes and extended register codes
`define FMM_EA_IND 3'h2
`define FMM_EA_POSTINC 3'h3
`define FMM_EA_PREDEC 3'h4
`define FMM_EA_DISP 3'h5
`define FMM_EA_IDX 3'h6
`define FMM_EA_EXT 3'h7
`define FMM_EXT_ABS_W 3'h0
`define FMM_EXT_ABS_L 3'h1
`define FMM_EXT_PC_DISP 3'h2
`define FMM_EXT_PC_IDX 3'h3
// Transfer sizes
`define FMM_IMG_BYTES 32'h0000000c
`define FMM_LAST_WORD 3'h5
// Control and status bits
`define FMM_CTRL_GO 0
`define FMM_ST_BUSY 0
`define FMM_ST_DONE 1
`define FMM_ST_PERR 2
`define FMM_ST_IDMISS 3
`define FMM_ST_DIR 4
`define FMM_ST_DYN 5
`define FMM_ST_CUR 10:8
`define FMM_ST_DYNREG 14:12
`define FMM_ST_WCNT 18:16
`define FMM_ST_PEND 31:24
// Reset values
`define FMM_ID_RST 3'h1
`define FMM_WORD_RST 16'h0000
`define FMM_LONG_RST 32'h00000000
`endif

/* File: hw/fmm_ea_check.v */
// Legality check of direction, list mode and effective address
`timescale 1ns/10ps
`include "fmm_defines.vh"
module fmm_ea_check (
  input  wire [15:0] op_i,
  input  wire [15:0] ext_i,
  output reg         legal_o
);
  reg       ea_ok;
  reg       fmt_ok;
  reg       mode_ok;
  reg [2:0] eam;
  reg [2:0] ear;

  // Addressing mode table per direction, plus fixed fields
  always @* begin
    eam = op_i[`FMM_OP_EAM];
    ear = op_i[`FMM_OP_EAR];
    ea_ok = 1'b0;
    if (ext_i[`FMM_EX_DIR] == 1'b0) begin
      // Memory to registers: no direct, predecrement or immediate
      case (eam)
        `FMM_EA_IND, `FMM_EA_POSTINC, `FMM_EA_DISP, `FMM_EA_IDX: ea_ok = 1'b1;
        `FMM_EA_EXT: ea_ok = (ear == `FMM_EXT_ABS_W) || (ear == `FMM_EXT_ABS_L) ||
                             (ear == `FMM_EXT_PC_DISP) || (ear == `FMM_EXT_PC_IDX);
        default: ea_ok = 1'b0;
      endcase
    end else begin
      // Registers to memory: no direct, postincrement, immediate or PC modes
      case (eam)
        `FMM_EA_IND, `FMM_EA_PREDEC, `FMM_EA_DISP, `FMM_EA_IDX: ea_ok = 1'b1;
        `FMM_EA_EXT: ea_ok = (ear == `FMM_EXT_ABS_W) || (ear == `FMM_EXT_ABS_L);
        default: ea_ok = 1'b0;
      endcase
    end
    // Predecrement list modes only pair with the predecrement address mode
    mode_ok = (ext_i[`FMM_MODE_POST + `FMM_EX_MODE_LO] == 1'b0) ? (eam == `FMM_EA_PREDEC)
                                                    : (eam != `FMM_EA_PREDEC);
    // Dynamic list carries only a register number in its middle bits
    fmt_ok = (op_i[`FMM_OP_SIG] == `FMM_OP_SIG_VAL) && (op_i[`FMM_OP_ZERO] == 3'h0) &&
             (ext_i[`FMM_EX_SIG] == `FMM_EX_SIG_VAL) && (ext_i[`FMM_EX_ZERO] == 3'h0) &&
             (!ext_i[`FMM_MODE_DYN + `FMM_EX_MODE_LO] ||
              ((ext_i[`FMM_EX_LIST] & `FMM_DYN_ZMASK) == 8'h00));
    legal_o = ea_ok && mode_ok && fmt_ok;
  end
endmodule // fmm_ea_check

/* File: hw/fmm_next_sel.v */
// Picks the next pending data register in the order of the transfer
`timescale 1ns/10ps
module fmm_next_sel (
  input  wire [7:0] pend_i,
  input  wire       down_i,
  output reg        found_o,
  output reg  [2:0] idx_o
);
  integer i;

  // Downward order wants the highest set bit, upward the lowest
  always @* begin
    found_o = 1'b0;
    idx_o = 3'h0;
    for (i = 0; i < 8; i = i + 1) begin
      if (down_i && pend_i[i]) begin
        found_o = 1'b1;
        idx_o = i[2:0];
      end
      if (!down_i && pend_i[7 - i]) begin
        found_o = 1'b1;
        idx_o = 3'h7 - i[2:0];
      end
    end
  end
endmodule // fmm_next_sel

/* File: verif/fmm_move_multiple_properties.sv */
// Concurrent checks at the move-multiple decoder's ports
`timescale 1ns/10ps
`include "fmm_defines.vh"
module fmm_move_multiple_properties (
  input wire        mclk_i,
  input wire        sys_rst_i,
  input wire [7:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        busy_o,
  input wire        proto_err_o
);
  logic [15:0] op_q;
  logic [15:0] ext_q;
  logic [31:0] fst_q;
  logic [2:0]  id_q;
  wire         acc_w = avs_write_i && !avs_waitrequest_o && !busy_o;
  wire         go    = acc_w && avs_address_i == `FMM_A_CTRL && avs_writedata_i[0];
  // Shadow of accepted writes; writes while busy are dropped by the block
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      op_q <= 16'h0000;
      ext_q <= 16'h0000;
      fst_q <= 32'h00000000;
      id_q <= `FMM_ID_RST;
    end else if (acc_w) begin
      if (avs_address_i == `FMM_A_OPWORD) op_q <= avs_writedata_i[15:0];
      if (avs_address_i == `FMM_A_EXTWORD) ext_q <= avs_writedata_i[15:0];
      if (avs_address_i == `FMM_A_FSTAT) fst_q <= avs_writedata_i;
      if (avs_address_i == `FMM_A_IDCFG) id_q <= avs_writedata_i[2:0];
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // Start of a move and its refusal as separate steps
  // Only commands for this coprocessor are judged; others report an id miss
  sequence s_store; go && ext_q[13] && op_q[11:9] == id_q; endsequence
  sequence s_load; go && !ext_q[13] && op_q[11:9] == id_q; endsequence
  sequence s_err; ##[1:3] proto_err_o && !busy_o; endsequence
  a_store_postinc_err: assert property (s_store ##0 op_q[5:3] == 3'h3 |-> s_err)
    else $error("store with postincrement was not refused");
  a_store_pcrel_err: assert property (s_store ##0 op_q[5:0] == 6'h3a |-> s_err)
    else $error("store to a relative address was not refused");
  a_load_predec_err: assert property (s_load ##0 op_q[5:3] == 3'h4 |-> s_err)
    else $error("load with predecrement was not refused");
  a_perr_moves_none: assert property (proto_err_o |-> !busy_o)
    else $error("transfer running while error is flagged");
  a_predec_store_runs: assert property (s_store ##0 op_q[11:3] == 9'h044
    && op_q[15:12] == 4'hf && ext_q[15:14] == 2'b11 && ext_q[10:8] == 3'h0
    && ext_q[12:11] == 2'b00 && ext_q[7:0] != 8'h00 |-> ##[1:3] busy_o)
    else $error("legal store did not start");
  a_wait_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  a_req_answered: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("request not answered after one wait cycle");
  a_fstat_kept: assert property (avs_read_i && !avs_waitrequest_o
    && avs_address_i == `FMM_A_FSTAT |-> avs_readdata_o == fst_q)
    else $error("float status differs from last written value");
endmodule // fmm_move_multiple_properties
bind fmm_move_multiple fmm_move_multiple_properties u_props (.mclk_i(mclk_i),
  .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .busy_o(busy_o), .proto_err_o(proto_err_o));

/* File: verif/fmm_cpu_model.sv */
// Main processor model: register bus master and its own data registers
`timescale 1ns/10ps
`include "fmm_defines.vh"
module fmm_cpu_model (
  input  wire logic        mclk_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        wait_i,
  output logic [7:0]       addr_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic [3:0]       be_o,
  output logic [31:0]      wdata_o
);
  logic [31:0] dreg [0:7];
  // Idle bus from time zero
  initial begin
    addr_o = 8'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    be_o = 4'hf;
    wdata_o = 32'h00000000;
    foreach (dreg[i]) dreg[i] = 32'h00000000;
  end
  // One access held until waitrequest is seen low; no cycle count assumed
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    rd_o <= ~w;
    wr_o <= w;
    do @(posedge mclk_i); while (wait_i !== 1'b0);
    q = rdata_i;
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    wdata_o <= ~d; // Released lines must not keep the old value
  endtask
  // Hand the command over and start it
  task automatic start(input logic [15:0] op, input logic [15:0] ext,
                       input logic [2:0] dn, input logic [31:0] a);
    logic [31:0] q;
    acc(1'b1, `FMM_A_OPWORD, {16'h0000, op}, q);
    acc(1'b1, `FMM_A_EXTWORD, {16'h0000, ext}, q);
    acc(1'b1, `FMM_A_DYNSRC, dreg[dn], q);
    acc(1'b1, `FMM_A_ADDR, a, q);
    acc(1'b1, `FMM_A_CTRL, 32'h00000001, q);
  endtask
endmodule // fmm_cpu_model

/* File: verif/fmm_move_multiple_tb.sv */
// Self-checking bench for the move-multiple decoder
`timescale 1ns/10ps
`include "fmm_defines.vh"
module fmm_move_multiple_tb;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  addr;
  logic        rd;
  logic        wr;
  logic [3:0]  be;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        waitreq;
  logic        busy;
  logic        perr;
  int          num_errors = 0;
  int          n_checks = 0;
  // 125 MHz clock
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  fmm_cpu_model u_cpu (.mclk_i(mclk_i), .rdata_i(rdata), .wait_i(waitreq), .addr_o(addr),
    .rd_o(rd), .wr_o(wr), .be_o(be), .wdata_o(wdata));
  fmm_move_multiple u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .busy_o(busy), .proto_err_o(perr));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] q);
    u_cpu.acc(1'b0, a, 32'h00000000, q);
  endtask
  // Word k of register n's image; the pad word always reads zero
  function automatic logic [15:0] wv(input logic [2:0] n, input int k);
    return (k == 1) ? 16'h0000 : {n, 3'(k), 10'h2a5};
  endfunction
  // Runs one move through the registers in the order given, six words each
  task automatic do_move(input logic [15:0] op, input logic [15:0] ext, input logic [31:0] a,
                         input logic [2:0] ord [$], input logic [2:0] dn);
    logic [31:0] q;
    u_cpu.start(op, ext, dn, a);
    foreach (ord[i]) begin
      rd_reg(`FMM_A_STATUS, q);
      chk("cur_reg", {29'h0, ord[i]}, {29'h0, q[`FMM_ST_CUR]});
      chk("dir_dyn", {30'h0, ext[13], ext[11]}, {30'h0, q[`FMM_ST_DIR], q[`FMM_ST_DYN]});
      if (ext[11]) chk("dyn_reg", {29'h0, dn}, {29'h0, q[`FMM_ST_DYNREG]});
      for (int k = 0; k < 6; k++) begin
        u_cpu.acc(~ext[13], `FMM_A_DATA, {16'h0000, wv(ord[i], k)}, q);
        if (ext[13]) chk("data_word", {16'h0, wv(ord[i], k)}, {16'h0, q[15:0]});
      end
    end
    q = 32'h00000001;
    for (int i = 0; i < 20 && q[0] !== 1'b0; i++) rd_reg(`FMM_A_STATUS, q);
    chk("done", 32'h00000002, q & 32'h0000000f);
  endtask
  task automatic t_reset();
    logic [31:0] q;
    rd_reg(`FMM_A_STATUS, q);
    chk("status", 32'h00000000, q);
    rd_reg(`FMM_A_IDCFG, q);
    chk("idcfg", {29'h0, `FMM_ID_RST}, q);
    rd_reg(8'h30, q);
    chk("unmapped", 32'h00000000, q);
    $display("test reset done");
  endtask
  task automatic t_load();
    logic [31:0] q;
    u_cpu.acc(1'b1, `FMM_A_FSTAT, 32'h0f0fa5a5, q);
    do_move(16'hf218, 16'hd081, 32'h00000100, '{3'd0, 3'd7}, 3'd0);
    rd_reg(`FMM_A_ADDR, q);
    chk("addr_post", 32'h00000118, q);
    $display("test load done");
  endtask
  task automatic t_store();
    logic [31:0] q;
    do_move(16'hf220, 16'he081, 32'h00000200, '{3'd7, 3'd0}, 3'd0);
    rd_reg(`FMM_A_ADDR, q);
    chk("addr_pre", 32'h000001e8, q);
    rd_reg(`FMM_A_FSTAT, q);
    chk("fstat", 32'h0f0fa5a5, q);
    // Control modes: displacement load, absolute long store, ADDR left alone
    do_move(16'hf228, 16'hd010, 32'h00000500, '{3'd3}, 3'd0);
    do_move(16'hf239, 16'hf010, 32'h00000500, '{3'd3}, 3'd0);
    rd_reg(`FMM_A_ADDR, q);
    chk("addr_ctrl_mode", 32'h00000500, q);
    $display("test store done");
  endtask
  // Dynamic lists: upper bits of the source register are ignored
  task automatic t_dyn();
    logic [31:0] q;
    u_cpu.dreg[3] = 32'hffffff01;
    do_move(16'hf210, 16'hf830, 32'h00000300, '{3'd7}, 3'd3);
    rd_reg(`FMM_A_ADDR, q);
    chk("addr_ctrl", 32'h00000300, q);
    do_move(16'hf220, 16'he830, 32'h00000300, '{3'd0}, 3'd3);
    rd_reg(`FMM_A_ADDR, q);
    chk("addr_dynpre", 32'h000002f4, q);
    $display("test dynamic done");
  endtask
  // Refused combinations: error flagged, nothing moves
  task automatic t_illegal();
    logic [31:0] q;
    logic [15:0] tbl [6][2] = '{'{16'hf220, 16'hc081}, '{16'hf218, 16'hf081},
      '{16'hf23a, 16'hf081}, '{16'hf200, 16'hd081}, '{16'hf23c, 16'hd081},
      '{16'hf210, 16'hf831}};
    foreach (tbl[i]) begin
      u_cpu.start(tbl[i][0], tbl[i][1], 3'd0, 32'h00000400);
      rd_reg(`FMM_A_STATUS, q);
      chk("perr_status", 32'h00000004, q & 32'h0000000f);
      chk("perr_pins", 32'h00000001, {30'h0, busy, perr});
    end
    u_cpu.start(16'hf418, 16'hd081, 3'd0, 32'h00000400);
    rd_reg(`FMM_A_STATUS, q);
    chk("idmiss", 32'h00000008, q & 32'h0000000f);
    $display("test illegal done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_load();
    t_store();
    t_dyn();
    t_illegal();
    close_out();
  end
  // Watchdog; the tests need well under two thousand cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    close_out();
  end
endmodule // fmm_move_multiple_tb
